/* File: include/usp_consts.svh */
// named offsets, bit positions, codes and counts for the serial port
// assumes byte-wide registers reached over a plain strobe port
`ifndef USP_CONSTS_SVH
`define USP_CONSTS_SVH
// register offsets
`define USP_OFS_HOLD 8'hb6
`define USP_OFS_BAUD 8'hb8
`define USP_OFS_PINCFG 8'hb9
`define USP_OFS_CTL 8'hba
`define USP_OFS_RXST 8'hbb
`define USP_OFS_ICC 8'hbc
// control and status field positions
`define USP_CTL_PEN 7
`define USP_CTL_PSEL_HI 6
`define USP_CTL_PSEL_LO 5
`define USP_CTL_ERR 2
`define USP_CTL_RXFULL 1
`define USP_CTL_TXEMPTY 0
// receive status field positions
`define USP_RXST_ATTENTION_MODE 2
// irq and clock control field positions
`define USP_ICC_TWO_STOP_SELECT 7
`define USP_ICC_BRK 6
`define USP_ICC_TX_PIN_SELECT 5
`define USP_ICC_SSEL 4
`define USP_ICC_RX_EXT_CLOCK_SELECT 3
`define USP_ICC_TX_EXT_CLOCK_SELECT 2
`define USP_ICC_ERI 1
`define USP_ICC_ETI 0
// pin configuration field positions
`define USP_PIN_TXOUT 0
`define USP_PIN_CKOUT 1
// reset values
`define USP_CTL_RST 5'h00
`define USP_ICC_RST 8'h00
`define USP_BAUD_RST 8'h00
`define USP_PIN_RST 2'h0
`define USP_BYTE_ZERO 8'h00
// character length codes
`define USP_CHL_8 2'h0
`define USP_CHL_7 2'h1
`define USP_CHL_9 2'h2
`define USP_CHL_LOOP 2'h3
// parity select codes
`define USP_PAR_ODD 2'h0
`define USP_PAR_EVEN 2'h1
`define USP_PAR_MARK 2'h2
`define USP_PAR_SPACE 2'h3
// 16x oversampling positions within one bit, and data bit counts
`define USP_SUB_LAST 4'hf
`define USP_HALF_BIT 4'h7
`define USP_VOTE_A 4'hd
`define USP_VOTE_B 4'he
`define USP_BITS_7 4'h7
`define USP_BITS_8 4'h8
`define USP_BITS_9 4'h9
`endif

/* File: include/usp_pkg.sv */
// types shared by the serial port design
// assumes nothing beyond a SystemVerilog package scope
package usp_pkg;
   typedef enum logic [1:0] {USP_RX_IDLE, USP_RX_START, USP_RX_DATA} usp_rx_state_type;

   // register bus request from software
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } usp_bus_req_type;

   // transmit frame image, start bit in bit 0
   typedef struct packed {
      logic [11:0] bits;
      logic [3:0] len;
   } usp_frame_type;

   // complete state of the serial port
   typedef struct packed {
      logic rx1, rx2, ck1, ck2, ck_prev;
      logic bclk_int;
      logic [7:0] baud_cnt, baud_div;
      logic [1:0] pin_cfg;
      logic [4:0] ctl;
      logic [7:0] icc;
      logic [7:0] tx_hold;
      logic tx_empty, tx_busy, tx_active;
      logic [11:0] tx_shift;
      logic [3:0] tx_left, tx_sub;
      usp_rx_state_type rx_state;
      logic [3:0] rx_sub, rx_idx;
      logic [9:0] rx_bits;
      logic [1:0] rx_votes;
      logic [7:0] rx_hold;
      logic rx_full, rx_ninth, attention, fault;
      logic f_over, f_frame, f_par, f_brk;
      logic serial_out, serial_en_n, ck_out, ck_en_n, tx_irq, rx_irq;
      logic [7:0] rdata;
   } usp_state_type;
endpackage

/* File: core/usp_serial_port.sv */
// full-duplex serial port: double-buffered tx/rx, parity, loopback, sync mode
// assumes pins and the external bit clock arrive unsynchronised to clock
`timescale 1ns/1ns
`include "usp_consts.svh"

module usp_serial_port
   import usp_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire usp_bus_req_type bus_req,
   output logic [7:0] rdata,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_en_n,
   input wire logic ext_bit_clock_pin_in,
   output logic ext_bit_clock_pin_out,
   output logic ext_bit_clock_pin_en_n,
   output logic tx_irq,
   output logic rx_irq
);

   usp_state_type st_reg, st_next;

   // data bits per frame for a length code
   function automatic logic [3:0] usp_nbits(input logic [1:0] chl);
      case (chl)
         `USP_CHL_8: usp_nbits = `USP_BITS_8;
         `USP_CHL_7: usp_nbits = `USP_BITS_7;
         default: usp_nbits = `USP_BITS_9;
      endcase
   endfunction

   // parity bit for the data part of a 7 or 8 bit character
   function automatic logic usp_parity(input logic [7:0] d, input logic [3:0] nb,
                                       input logic [1:0] psel);
      logic x;
      x = ^((nb == `USP_BITS_7) ? {1'b0, d[6:0]} : d);
      case (psel)
         `USP_PAR_ODD: usp_parity = ~x;
         `USP_PAR_EVEN: usp_parity = x;
         `USP_PAR_MARK: usp_parity = 1'b1;
         default: usp_parity = 1'b0;
      endcase
   endfunction

   // position of the parity or ninth bit after the data bits
   function automatic logic [3:0] usp_extra_pos(input logic [3:0] nb);
      usp_extra_pos = (nb == `USP_BITS_9) ? `USP_BITS_8 : nb;
   endfunction

   // whole frame image for the shifter, lsb first
   function automatic usp_frame_type usp_build(input logic [7:0] d, input logic [4:0] c,
                                              input logic two_stop_select);
      usp_frame_type f;
      logic [3:0] nb;
      logic [3:0] i;
      f.bits = 12'hfff;
      f.bits[0] = 1'b0;
      nb = usp_nbits(c[1:0]);
      for (int k = 0; k < 8; k++)
      begin
         if (4'(k) < nb)
            f.bits[k + 1] = d[k];
      end
      i = 4'(usp_extra_pos(nb) + 4'h1);
      if (nb == `USP_BITS_9)
      begin
         f.bits[i] = c[2];
         i = 4'(i + 4'h1);
      end
      else if (c[4])
      begin
         f.bits[i] = usp_parity(d, nb, c[3:2]);
         i = 4'(i + 4'h1);
      end
      f.len = 4'(i + (two_stop_select ? 4'h2 : 4'h1));
      usp_build = f;
   endfunction

   // next-state logic
   always_comb
   begin
      logic int_rise, int_fall, ext_rise, ext_fall, sync_mode, wr_hold, rd_hold, rd_rxst;
      logic tx_tick, tx_bit_end, rx_tick, rx_line, rx_bit, stop_ok, par_bit;
      logic [3:0] nb, ppos, total;
      logic [9:0] bits_n;
      logic [7:0] data8, rd_val;
      usp_frame_type fr;
      int_rise = 1'b0;
      int_fall = 1'b0;
      ext_rise = 1'b0;
      ext_fall = 1'b0;
      sync_mode = 1'b0;
      wr_hold = 1'b0;
      rd_hold = 1'b0;
      rd_rxst = 1'b0;
      tx_tick = 1'b0;
      tx_bit_end = 1'b0;
      rx_tick = 1'b0;
      rx_line = 1'b1;
      rx_bit = 1'b0;
      stop_ok = 1'b0;
      par_bit = 1'b0;
      nb = 4'h0;
      ppos = 4'h0;
      total = 4'h0;
      bits_n = 10'h000;
      data8 = 8'h00;
      rd_val = 8'h00;
      fr = '0;
      st_next = st_reg;

      // pin synchronisers; ck_prev reads only the second stage
      st_next.rx1 = serial_in_pin;
      st_next.rx2 = st_reg.rx1;
      st_next.ck1 = ext_bit_clock_pin_in;
      st_next.ck2 = st_reg.ck1;
      st_next.ck_prev = st_reg.ck2;
      ext_rise = st_reg.ck2 && !st_reg.ck_prev;
      ext_fall = !st_reg.ck2 && st_reg.ck_prev;

      // internal bit clock: toggles every baud_div+1 cycles
      if (st_reg.baud_cnt == st_reg.baud_div)
      begin
         st_next.baud_cnt = 8'h00;
         st_next.bclk_int = !st_reg.bclk_int;
         int_rise = !st_reg.bclk_int;
         int_fall = st_reg.bclk_int;
      end
      else
         st_next.baud_cnt = 8'(st_reg.baud_cnt + 8'h01);

      sync_mode = st_reg.icc[`USP_ICC_SSEL];
      nb = usp_nbits(st_reg.ctl[1:0]);
      ppos = usp_extra_pos(nb);

      // register writes; transfer to shifter waits a cycle after a write
      if (bus_req.wr)
      begin
         case (bus_req.addr)
            `USP_OFS_HOLD:
            begin
               st_next.tx_hold = bus_req.wdata;
               st_next.tx_empty = 1'b0;
               wr_hold = 1'b1;
            end
            `USP_OFS_BAUD: st_next.baud_div = bus_req.wdata;
            `USP_OFS_PINCFG: st_next.pin_cfg = bus_req.wdata[1:0];
            `USP_OFS_CTL: st_next.ctl = bus_req.wdata[7:3];
            `USP_OFS_RXST: st_next.attention = bus_req.wdata[`USP_RXST_ATTENTION_MODE];
            `USP_OFS_ICC: st_next.icc = bus_req.wdata;
            default: ;
         endcase
      end

      // register reads; clears here are overridden by same-cycle sets below
      case (bus_req.addr)
         `USP_OFS_HOLD: rd_val = st_reg.rx_hold;
         `USP_OFS_BAUD: rd_val = st_reg.baud_div;
         `USP_OFS_PINCFG: rd_val = {6'h00, st_reg.pin_cfg};
         `USP_OFS_CTL:
            rd_val = {st_reg.ctl, st_reg.f_over | st_reg.f_frame | st_reg.f_par | st_reg.f_brk,
                      st_reg.rx_full, st_reg.tx_empty};
         `USP_OFS_RXST:
            rd_val = {st_reg.f_over, st_reg.f_frame, st_reg.f_par, st_reg.f_brk,
                      st_reg.rx_ninth, st_reg.attention, st_reg.tx_active, st_reg.fault};
         `USP_OFS_ICC: rd_val = st_reg.icc;
         default: rd_val = `USP_BYTE_ZERO;
      endcase
      st_next.rdata = bus_req.rd ? rd_val : `USP_BYTE_ZERO;
      rd_hold = bus_req.rd && (bus_req.addr == `USP_OFS_HOLD);
      rd_rxst = bus_req.rd && (bus_req.addr == `USP_OFS_RXST);
      if (rd_hold)
         st_next.rx_full = 1'b0;
      if (rd_rxst)
      begin
         st_next.f_over = 1'b0;
         st_next.f_frame = 1'b0;
         st_next.f_par = 1'b0;
         st_next.f_brk = 1'b0;
      end

      // transmitter: 16 ticks a bit async, one rising edge a bit sync
      tx_tick = st_reg.icc[`USP_ICC_TX_EXT_CLOCK_SELECT] ? ext_rise : int_rise;
      tx_bit_end = tx_tick && (sync_mode || st_reg.tx_sub == `USP_SUB_LAST);
      if (st_reg.tx_busy)
      begin
         if (tx_tick)
            st_next.tx_sub = 4'(st_reg.tx_sub + 4'h1);
         if (tx_bit_end)
         begin
            st_next.tx_shift = {1'b1, st_reg.tx_shift[11:1]};
            st_next.tx_left = 4'(st_reg.tx_left - 4'h1);
            if (st_reg.tx_left == 4'h1)
            begin
               st_next.tx_busy = 1'b0;
               st_next.tx_active = !st_reg.tx_empty;
            end
         end
      end
      else if (!st_reg.tx_empty && !wr_hold)
      begin
         fr = usp_build(st_reg.tx_hold, st_reg.ctl, st_reg.icc[`USP_ICC_TWO_STOP_SELECT]);
         st_next.tx_shift = fr.bits;
         st_next.tx_left = fr.len;
         st_next.tx_sub = 4'h0;
         st_next.tx_busy = 1'b1;
         st_next.tx_active = 1'b1;
         st_next.tx_empty = 1'b1;
      end
      // idle line high, break forces low
      if (st_reg.icc[`USP_ICC_BRK])
         st_next.serial_out = 1'b0;
      else
         st_next.serial_out = st_next.tx_busy ? st_next.tx_shift[0] : 1'b1;
      st_next.serial_en_n = !(st_reg.icc[`USP_ICC_TX_PIN_SELECT] && st_reg.pin_cfg[`USP_PIN_TXOUT]);
      st_next.ck_out = st_reg.bclk_int;
      st_next.ck_en_n = !st_reg.pin_cfg[`USP_PIN_CKOUT];

      // receiver line and tick; loopback reads the internal tx line
      rx_line = (st_reg.ctl[1:0] == `USP_CHL_LOOP) ? st_reg.serial_out : st_reg.rx2;
      if (st_reg.icc[`USP_ICC_RX_EXT_CLOCK_SELECT])
         rx_tick = sync_mode ? ext_fall : ext_rise;
      else
         rx_tick = sync_mode ? int_fall : int_rise;
      total = 4'(ppos + ((nb == `USP_BITS_9 || st_reg.ctl[4]) ? 4'h1 : 4'h0) + 4'h1);

      // fault clears on line high; a same-cycle fault sets it again below
      if (rx_line)
         st_next.fault = 1'b0;

      case (st_reg.rx_state)
         USP_RX_IDLE:
         begin
            if (rx_tick && !rx_line)
            begin
               st_next.rx_sub = 4'h0;
               st_next.rx_idx = 4'h0;
               st_next.rx_state = sync_mode ? USP_RX_DATA : USP_RX_START;
            end
         end
         USP_RX_START:
         begin
            if (rx_tick)
            begin
               st_next.rx_sub = 4'(st_reg.rx_sub + 4'h1);
               // recheck half a bit later; a high line was only a glitch
               if (st_reg.rx_sub == `USP_HALF_BIT)
               begin
                  st_next.rx_sub = 4'h0;
                  st_next.rx_state = rx_line ? USP_RX_IDLE : USP_RX_DATA;
               end
            end
         end
         USP_RX_DATA:
         begin
            if (rx_tick)
            begin
               st_next.rx_sub = 4'(st_reg.rx_sub + 4'h1);
               if (st_reg.rx_sub == `USP_VOTE_A)
                  st_next.rx_votes[0] = rx_line;
               if (st_reg.rx_sub == `USP_VOTE_B)
                  st_next.rx_votes[1] = rx_line;
            end
            if (rx_tick && (sync_mode || st_reg.rx_sub == `USP_SUB_LAST))
            begin
               // async: majority of three samples around the centre; sync: the line sampled once
               rx_bit = sync_mode ? rx_line :
                        (st_reg.rx_votes[0] & st_reg.rx_votes[1]) |
                        (st_reg.rx_votes[0] & rx_line) |
                        (st_reg.rx_votes[1] & rx_line);
               bits_n = st_reg.rx_bits;
               bits_n[st_reg.rx_idx] = rx_bit;
               st_next.rx_bits = bits_n;
               st_next.rx_idx = 4'(st_reg.rx_idx + 4'h1);
               if (st_reg.rx_idx == 4'(total - 4'h1))
               begin
                  st_next.rx_state = USP_RX_IDLE;
                  stop_ok = rx_bit;
                  data8 = bits_n[7:0];
                  if (nb == `USP_BITS_7)
                     data8[7] = 1'b0;
                  par_bit = bits_n[ppos];
                  if (!stop_ok)
                  begin
                     st_next.f_frame = 1'b1;
                     st_next.fault = 1'b1;
                  end
                  if (!stop_ok && data8 == `USP_BYTE_ZERO && !par_bit)
                     st_next.f_brk = 1'b1;
                  if (st_reg.ctl[4] && nb != `USP_BITS_9 &&
                      par_bit != usp_parity(data8, nb, st_reg.ctl[3:2]))
                     st_next.f_par = 1'b1;
                  // attention drops characters whose ninth bit is zero
                  if (!(st_reg.attention && nb == `USP_BITS_9 && !par_bit))
                  begin
                     if (st_reg.rx_full && !rd_hold)
                        st_next.f_over = 1'b1;
                     st_next.rx_hold = data8;
                     st_next.rx_ninth = (nb == `USP_BITS_9) && par_bit;
                     st_next.rx_full = 1'b1;
                     if (nb == `USP_BITS_9 && par_bit)
                        st_next.attention = 1'b0;
                  end
               end
            end
         end
         default: st_next.rx_state = USP_RX_IDLE;
      endcase

      // interrupt levels, registered
      st_next.tx_irq = st_reg.tx_empty && st_reg.icc[`USP_ICC_ETI];
      st_next.rx_irq = st_reg.rx_full && st_reg.icc[`USP_ICC_ERI];
   end

   // state register with synchronous reset
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
         st_reg.rx1 <= 1'b1;
         st_reg.rx2 <= 1'b1;
         st_reg.ctl <= `USP_CTL_RST;
         st_reg.icc <= `USP_ICC_RST;
         st_reg.baud_div <= `USP_BAUD_RST;
         st_reg.pin_cfg <= `USP_PIN_RST;
         st_reg.rx_state <= USP_RX_IDLE;
         st_reg.tx_empty <= 1'b1;
         st_reg.serial_out <= 1'b1;
         st_reg.serial_en_n <= 1'b1;
         st_reg.ck_en_n <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // outputs straight from the state register
   assign rdata = st_reg.rdata;
   assign serial_out_pin = st_reg.serial_out;
   assign serial_out_en_n = st_reg.serial_en_n;
   assign ext_bit_clock_pin_out = st_reg.ck_out;
   assign ext_bit_clock_pin_en_n = st_reg.ck_en_n;
   assign tx_irq = st_reg.tx_irq;
   assign rx_irq = st_reg.rx_irq;

   // checks beside the logic
   a_break_holds_low: assert property (@(posedge clock) disable iff (!rstn)
      st_reg.icc[`USP_ICC_BRK] |=> !serial_out_pin)
      else $error("break set but transmit line not low");

   a_write_clears_empty: assert property (@(posedge clock) disable iff (!rstn)
      bus_req.wr && bus_req.addr == `USP_OFS_HOLD |=> !st_reg.tx_empty ##1 st_reg.tx_empty
      || st_reg.tx_busy)
      else $error("holding write did not clear empty flag");

   a_read_clears_full: assert property (@(posedge clock) disable iff (!rstn)
      bus_req.rd && bus_req.addr == `USP_OFS_HOLD && st_reg.rx_state != USP_RX_DATA
      |=> !st_reg.rx_full)
      else $error("holding read did not clear full flag");

   a_status_read_clear: assert property (@(posedge clock) disable iff (!rstn)
      bus_req.rd && bus_req.addr == `USP_OFS_RXST && st_reg.rx_state != USP_RX_DATA
      |=> !(st_reg.f_over | st_reg.f_frame | st_reg.f_par | st_reg.f_brk))
      else $error("status read left error flags set");

   a_error_summary: assert property (@(posedge clock) disable iff (!rstn)
      bus_req.rd && bus_req.addr == `USP_OFS_CTL
      |=> rdata[`USP_CTL_ERR] == $past(st_reg.f_over | st_reg.f_frame | st_reg.f_par
      | st_reg.f_brk))
      else $error("summary error bit disagrees with flags");

   a_tx_irq_level: assert property (@(posedge clock) disable iff (!rstn)
      st_reg.tx_empty && st_reg.icc[`USP_ICC_ETI] ##1 st_reg.tx_empty |-> tx_irq)
      else $error("transmit interrupt not pending");

   a_rx_irq_level: assert property (@(posedge clock) disable iff (!rstn)
      !st_reg.icc[`USP_ICC_ERI] |=> !rx_irq)
      else $error("receive interrupt raised while disabled");

   a_idle_line_high: assert property (@(posedge clock) disable iff (!rstn)
      !st_reg.tx_busy && !st_reg.icc[`USP_ICC_BRK] && !st_next.tx_busy |=> serial_out_pin)
      else $error("transmit line low while idle");

   a_attention_clear: assert property (@(posedge clock) disable iff (!rstn)
      $rose(st_reg.rx_ninth) |-> !st_reg.attention)
      else $error("attention kept after ninth bit one");

   a_start_reject: assert property (@(posedge clock) disable iff (!rstn)
      st_reg.rx_state == USP_RX_START && st_next.rx_state != USP_RX_START
      |-> (st_next.rx_state == USP_RX_IDLE) == ((st_reg.ctl[1:0] == `USP_CHL_LOOP) ?
      st_reg.serial_out : st_reg.rx2))
      else $error("start bit decision disagrees with line level");
endmodule

/* File: bench/usp_peer_model.sv */
// remote async serial device: sends frames and captures eight-bit frames
// assumes divisor 0, so sixteen ticks of two clocks make one 3200 ns bit
`timescale 1ns/1ns
module usp_peer_model
#(
   parameter int BIT_NS = 3200
)
(
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] rx_byte;
   int rx_count;
   // idle high, as a pulled-up receive pin would sit
   initial
   begin
      line_out = 1'b1;
      rx_byte = 8'h00;
      rx_count = 0;
   end
   // start, eight data lsb first, one stop of the chosen level, one idle bit
   task automatic send(input logic [7:0] d, input logic stop);
      line_out <= 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++)
      begin
         line_out <= d[i];
         #(BIT_NS);
      end
      line_out <= stop;
      #(BIT_NS);
      line_out <= 1'b1;
      #(BIT_NS);
   endtask
   // sample mid-bit; a frame counts only with a high stop bit
   always @(negedge line_in)
   begin
      #(BIT_NS / 2);
      if (line_in === 1'b0)
      begin
         for (int i = 0; i < 8; i++)
         begin
            #(BIT_NS);
            rx_byte[i] = line_in;
         end
         #(BIT_NS);
         if (line_in === 1'b1)
            rx_count++;
      end
   end
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the serial port: registers, tx, rx, errors, break
// assumes the peer model and a free-running 800 ns external bit clock
`timescale 1ns/1ns
`include "usp_consts.svh"
module tb_top;
   import usp_pkg::*;
   logic clock, rstn, serial_out_pin, serial_out_en_n, ck_out, ck_en_n, tx_irq, rx_irq;
   logic ext_clk, wire_tx, peer_tx;
   logic [7:0] rdata, v;
   usp_bus_req_type bus_req;
   int n_errors = 0;
   int num_checks = 0;
   // wire pulled high whenever the port releases it
   assign wire_tx = serial_out_en_n ? 1'b1 : serial_out_pin;
   usp_serial_port dut (.clock(clock), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
      .serial_in_pin(peer_tx), .serial_out_pin(serial_out_pin),
      .serial_out_en_n(serial_out_en_n), .ext_bit_clock_pin_in(ext_clk),
      .ext_bit_clock_pin_out(ck_out), .ext_bit_clock_pin_en_n(ck_en_n),
      .tx_irq(tx_irq), .rx_irq(rx_irq));
   usp_peer_model peer (.line_in(wire_tx), .line_out(peer_tx));
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // external clock, phase unrelated to the system clock
   initial
   begin
      ext_clk = 1'b0;
      #13;
      forever #400 ext_clk = ~ext_clk;
   end
   task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_rx(input int n);
      for (int i = 0; i < 4000 && peer.rx_count < n; i++)
         @(posedge clock);
      chk("peer frames", 8'(peer.rx_count), 8'(n));
   endtask
   task automatic t_reset();
      rd(`USP_OFS_CTL, v);
      chk("ctl reset", v, 8'h01);
      rd(`USP_OFS_RXST, v);
      chk("rxst reset", v, 8'h00);
      rd(`USP_OFS_ICC, v);
      chk("icc reset", v, `USP_ICC_RST);
      rd(8'hc0, v);
      chk("unmapped", v, 8'h00);
      $display("reset test done");
   endtask
   // two writes back to back: second waits in holding while first shifts
   task automatic t_tx();
      wr(`USP_OFS_PINCFG, 8'h03);
      wr(`USP_OFS_ICC, 8'h21);
      repeat (3) @(posedge clock);
      #1 v[0] = ck_out;
      chk("tx irq", {7'h0, tx_irq}, 8'h01);
      chk("tx pin enable", {7'h0, serial_out_en_n}, 8'h00);
      chk("clock pin enable", {7'h0, ck_en_n}, 8'h00);
      @(posedge clock);
      #1 chk("clock pin toggles", {7'h0, ck_out}, {7'h0, ~v[0]});
      wr(`USP_OFS_HOLD, 8'ha5);
      wr(`USP_OFS_HOLD, 8'h5a);
      rd(`USP_OFS_CTL, v);
      chk("tx empty low", v & 8'h01, 8'h00);
      rd(`USP_OFS_RXST, v);
      chk("tx active", v & 8'h02, 8'h02);
      wait_rx(1);
      chk("first byte", peer.rx_byte, 8'ha5);
      wait_rx(2);
      chk("second byte", peer.rx_byte, 8'h5a);
      repeat (40) @(posedge clock);
      rd(`USP_OFS_RXST, v);
      chk("tx idle", v & 8'h02, 8'h00);
      $display("transmit test done");
   endtask
   task automatic t_rx();
      wr(`USP_OFS_ICC, 8'h02);
      peer.send(8'h3c, 1'b1);
      rd(`USP_OFS_CTL, v);
      chk("rx full", v, 8'h03);
      chk("rx irq", {7'h0, rx_irq}, 8'h01);
      rd(`USP_OFS_HOLD, v);
      chk("rx byte", v, 8'h3c);
      rd(`USP_OFS_CTL, v);
      chk("rx full clear", v, 8'h01);
      peer.send(8'h11, 1'b1);
      peer.send(8'h22, 1'b1);
      rd(`USP_OFS_CTL, v);
      chk("err summary", v & 8'h04, 8'h04);
      rd(`USP_OFS_RXST, v);
      chk("overrun", v & 8'hf0, 8'h80);
      rd(`USP_OFS_RXST, v);
      chk("flags cleared", v & 8'hf0, 8'h00);
      rd(`USP_OFS_HOLD, v);
      chk("overwritten", v, 8'h22);
      peer.send(8'h55, 1'b0);
      rd(`USP_OFS_RXST, v);
      chk("framing", v & 8'hf0, 8'h40);
      rd(`USP_OFS_HOLD, v);
      chk("framed byte", v, 8'h55);
      $display("receive test done");
   endtask
   task automatic t_brk();
      wr(`USP_OFS_ICC, 8'h60);
      repeat (3) @(posedge clock);
      chk("break line", {7'h0, wire_tx}, 8'h00);
      wr(`USP_OFS_ICC, 8'h00);
      $display("break test done");
   endtask
   // seven data bits with odd parity; the peer's eighth bit carries the parity
   task automatic t_par();
      wr(`USP_OFS_CTL, 8'h88);
      peer.send(8'h83, 1'b1);
      rd(`USP_OFS_RXST, v);
      chk("parity good", v & 8'hf0, 8'h00);
      rd(`USP_OFS_HOLD, v);
      chk("seven bits", v, 8'h03);
      peer.send(8'h03, 1'b1);
      rd(`USP_OFS_RXST, v);
      chk("parity bad", v & 8'hf0, 8'h20);
      rd(`USP_OFS_HOLD, v);
      chk("parity byte", v, 8'h03);
      wr(`USP_OFS_ICC, 8'h20);
      wr(`USP_OFS_HOLD, 8'h05);
      wait_rx(3);
      chk("parity sent", peer.rx_byte, 8'h85);
      $display("parity test done");
   endtask
   // loopback nine-bit frames: attention drops a zero ninth bit, keeps a one
   task automatic t_loop();
      wr(`USP_OFS_RXST, 8'h04);
      wr(`USP_OFS_CTL, 8'h18);
      wr(`USP_OFS_HOLD, 8'h66);
      repeat (420) @(posedge clock);
      rd(`USP_OFS_CTL, v);
      chk("attention drop", v, 8'h19);
      rd(`USP_OFS_RXST, v);
      chk("attention kept", v & 8'h0c, 8'h04);
      // two stop bits keep the sender busy after the receiver took the frame
      wr(`USP_OFS_ICC, 8'h80);
      wr(`USP_OFS_CTL, 8'h38);
      wr(`USP_OFS_HOLD, 8'h99);
      repeat (366) @(posedge clock);
      rd(`USP_OFS_RXST, v);
      chk("ninth bit", v & 8'hfe, 8'h0a);
      rd(`USP_OFS_HOLD, v);
      chk("loop byte", v, 8'h99);
      $display("loopback test done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      rstn = 1'b0;
      bus_req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      t_reset();
      t_tx();
      t_rx();
      t_par();
      t_brk();
      t_loop();
      tally_and_finish();
   end
   // watchdog well beyond the few frames the tests send
   initial
   begin
      #5000000;
      n_errors++;
      tally_and_finish();
   end
endmodule
